// ===== design/glab_top.sv
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module glab_top (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [15:0] pin_freeze_bit,
	output logic [31:0] alt_function_select_low,
	output logic [31:0] alt_function_select_high,
	output logic [15:0] pin_output_clear_bit,
	output logic pin_output_clear_stb
);
	import glab_pkg::*;

	// ****************************************
	// Bus slave
	// ****************************************
	// One wait cycle per access keeps read data registered
	logic ack_reg;
	logic ack_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [15:0] lock_reg;
	logic [15:0] lock_next;
	logic [15:0] clr_reg;
	logic [15:0] clr_next;
	logic clr_stb_reg;
	logic clr_stb_next;
	logic key_active;
	logic [31:0] wmask;
	logic [31:0] wdata_m;
	logic [31:0] alfl_q;
	logic [31:0] alfh_q;
	logic [31:0] lock_lo_m;
	logic [31:0] lock_hi_m;
	logic do_wr;

	// Expands per-pin lock bits to 4-bit selector fields
	function automatic logic [31:0] glab_expand(input logic [7:0] lk);
		logic [31:0] r;
		r = ZERO_WORD;
		for (int i = 0; i < 8; i++) begin
			r[i*SEL_WIDTH +: SEL_WIDTH] = {SEL_WIDTH{lk[i]}};
		end
		return r;
	endfunction : glab_expand

	// Byte enables masked onto write data
	generate
		for (genvar b = 0; b < 4; b++) begin : g_be
			assign wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
		end
	endgenerate

	assign do_wr = avs_write && !ack_reg;
	assign wdata_m = avs_writedata & wmask;
	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
	assign lock_lo_m = glab_expand(lock_reg[7:0]);
	assign lock_hi_m = glab_expand(lock_reg[15:8]);

	// Access completes on the cycle after it is seen
	always_comb begin
		ack_next = (avs_read || avs_write) && !ack_reg;
		rdata_next = rdata_reg;
		if (avs_read && !ack_reg) begin
			case (avs_address)
				OFS_LOCK: rdata_next = {15'h0000, key_active, lock_reg};
				OFS_ALFL: rdata_next = alfl_q;
				OFS_ALFH: rdata_next = alfh_q;
				OFS_BCLR: rdata_next = ZERO_WORD;
				default: rdata_next = ZERO_WORD;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_reg <= 1'b0;
			rdata_reg <= RESET_VALUE;
		end else begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	assign avs_readdata = rdata_reg;

	// ****************************************
	// Lock bits
	// ****************************************
	// Writes land only while the key is still inactive
	always_comb begin
		lock_next = lock_reg;
		if (do_wr && avs_address == OFS_LOCK && !key_active) begin
			lock_next = (lock_reg & ~wmask[15:0]) | wdata_m[15:0];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			lock_reg <= RESET_VALUE[15:0];
		end else begin
			lock_reg <= lock_next;
		end
	end

	assign pin_freeze_bit = lock_reg;

	// Tracker sees the byte-enable-masked word; partial writes still count as steps
	glab_key_seq u_key (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.lock_wr(do_wr && avs_address == OFS_LOCK),
		.wdata(wdata_m),
		.key_active(key_active)
	);

	// ****************************************
	// Function selectors
	// ****************************************
	// Unwritten byte lanes behave as locked so they keep their value
	glab_regs u_alfl (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.wr(do_wr && avs_address == OFS_ALFL),
		.wdata(wdata_m),
		.locked(lock_lo_m | ~wmask),
		.q(alfl_q)
	);

	glab_regs u_alfh (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.wr(do_wr && avs_address == OFS_ALFH),
		.wdata(wdata_m),
		.locked(lock_hi_m | ~wmask),
		.q(alfh_q)
	);

	assign alt_function_select_low = alfl_q;
	assign alt_function_select_high = alfh_q;

	// ****************************************
	// Output clear strobe
	// ****************************************
	// One-cycle pulse; the output data register applies the mask
	always_comb begin
		clr_next = ZERO_WORD[15:0];
		clr_stb_next = 1'b0;
		if (do_wr && avs_address == OFS_BCLR) begin
			clr_next = wdata_m[15:0];
			clr_stb_next = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			clr_reg <= RESET_VALUE[15:0];
			clr_stb_reg <= 1'b0;
		end else begin
			clr_reg <= clr_next;
			clr_stb_reg <= clr_stb_next;
		end
	end

	assign pin_output_clear_bit = clr_reg;
	assign pin_output_clear_stb = clr_stb_reg;

	// ****************************************
	// Checks
	// ****************************************
	// Helper terms keep the sampled-value functions on plain signals
	logic lock_wr_c;
	logic clr_wr_c;
	logic rd_seen_c;
	logic [15:0] wr_pins;
	logic wr_key;

	// Decoded access terms, looked at only by the properties below
	assign lock_wr_c = do_wr && avs_address == OFS_LOCK;
	assign clr_wr_c = do_wr && avs_address == OFS_BCLR;
	assign rd_seen_c = avs_read && !ack_reg;
	assign wr_pins = wdata_m[15:0];
	assign wr_key = wdata_m[KEY_BIT];

	// A full-word lock write that the key still lets through
	sequence lock_write_s;
		lock_wr_c && !key_active && avs_byteenable == 4'hf;
	endsequence

	// A request seen while no answer is pending
	sequence bus_req_s;
		(avs_read || avs_write) && !ack_reg;
	endsequence

	// Exactly one wait cycle, then the answer
	sequence bus_ans_s;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence

	// Clear strobe stands one cycle, then drops
	sequence clr_pulse_s;
		pin_output_clear_stb ##1 !pin_output_clear_stb;
	endsequence

	// Lock read while the key is still off
	sequence lock_read_open_s;
		rd_seen_c && avs_address == OFS_LOCK && !key_active;
	endsequence

	// ****************************************
	// Lock and key properties
	// ****************************************
	lock_frozen_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		key_active |=> $stable(lock_reg))
		else $error("lock bits changed while frozen");
	lock_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!lock_wr_c |=> $stable(lock_reg))
		else $error("lock bits changed without a lock write");
	lock_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		lock_write_s |=> lock_reg == $past(wr_pins))
		else $error("lock write lost");
	key_read_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(rd_seen_c && avs_address == OFS_LOCK && key_active) |=> avs_readdata[KEY_BIT])
		else $error("key read not one");
	key_off_read_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		lock_read_open_s |=> !avs_readdata[KEY_BIT])
		else $error("key read one while inactive");
	// Key can only rise right after a lock write with the key bit set
	key_needs_seq_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		$rose(key_active) |-> $past(lock_wr_c) && $past(wr_key))
		else $error("key rose without final write");
	// No disable here: this looks at the first edge after release
	reset_clear_a: assert property (@(posedge core_clk)
		$rose(arst_n) |-> !key_active && lock_reg == RESET_VALUE[15:0] &&
		alfl_q == RESET_VALUE && alfh_q == RESET_VALUE)
		else $error("state not cleared by reset");

	// ****************************************
	// Selector properties
	// ****************************************
	sel_locked_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(lock_reg[0] && $past(lock_reg[0])) |-> $stable(alfl_q[3:0]))
		else $error("locked selector changed");
	sel_high_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(lock_reg[15] && $past(lock_reg[15])) |-> $stable(alfh_q[31:28]))
		else $error("locked high selector changed");
	// Every locked pin keeps its selector nibble, in both registers
	for (genvar p = 0; p < PIN_COUNT / 2; p++) begin : g_sel_chk
		localparam int HI_PIN = p + PIN_COUNT / 2;
		sel_lo_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
			(lock_reg[p] && $past(lock_reg[p])) |->
			$stable(alfl_q[p*SEL_WIDTH +: SEL_WIDTH]))
			else $error("locked low selector changed");
		sel_hi_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
			(lock_reg[HI_PIN] && $past(lock_reg[HI_PIN])) |->
			$stable(alfh_q[p*SEL_WIDTH +: SEL_WIDTH]))
			else $error("locked high selector changed");
	end

	// ****************************************
	// Bus and clear-strobe properties
	// ****************************************
	ack_once_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		bus_req_s |=> !avs_waitrequest)
		else $error("bus access not answered");
	wait_state_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		bus_req_s |-> bus_ans_s)
		else $error("wait state count wrong");
	// Read data stands until the next read is taken
	rdata_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!rd_seen_c |=> $stable(avs_readdata))
		else $error("read data changed without a read");
	clr_read_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(rd_seen_c && avs_address == OFS_BCLR) |=> avs_readdata == ZERO_WORD)
		else $error("clear register read nonzero");
	clr_pulse_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		clr_wr_c |=> pin_output_clear_bit == $past(wr_pins) ##0 clr_pulse_s)
		else $error("clear pulse wrong");
	clr_quiet_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!clr_wr_c |=> !pin_output_clear_stb)
		else $error("clear strobe without a write");
	// Idle mask is zero, so a stray strobe could clear nothing
	clr_mask_idle_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!pin_output_clear_stb |-> pin_output_clear_bit == ZERO_WORD[15:0])
		else $error("clear mask set without strobe");
endmodule : glab_top
`default_nettype wire

// ===== design/glab_pkg.sv
package glab_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [5:0] OFS_LOCK = 6'h1c;
	localparam logic [5:0] OFS_ALFL = 6'h20;
	localparam logic [5:0] OFS_ALFH = 6'h24;
	localparam logic [5:0] OFS_BCLR = 6'h28;
	localparam int PIN_COUNT = 16;
	localparam int SEL_WIDTH = 4;
	localparam int KEY_BIT = 16;
	localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	// Highest legal selector code is alternate_function_7
	localparam logic [3:0] SEL_MAX = 4'h7;

	// Key sequence tracker states
	typedef enum logic [1:0] {
		GLAB_KEY_IDLE,
		GLAB_KEY_ONE,
		GLAB_KEY_ZERO,
		GLAB_KEY_DONE
	} glab_key_state_t;
endpackage : glab_pkg

// ===== design/glab_key_seq.sv
`timescale 1ns/1ps
`default_nettype none
module glab_key_seq (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic lock_wr,
	input wire logic [31:0] wdata,
	output logic key_active
);
	import glab_pkg::*;

	glab_key_state_t state_reg;
	glab_key_state_t state_next;
	logic [15:0] pins_reg;
	logic [15:0] pins_next;

	// ****************************************
	// Sequence tracker: 1, 0, 1 with same pin bits
	// ****************************************
	always_comb begin
		state_next = state_reg;
		pins_next = pins_reg;
		if (lock_wr && state_reg != GLAB_KEY_DONE) begin
			case (state_reg)
				GLAB_KEY_IDLE: begin
					if (wdata[KEY_BIT]) begin
						state_next = GLAB_KEY_ONE;
						pins_next = wdata[15:0];
					end
				end
				GLAB_KEY_ONE: begin
					// A zero with other pin bits drops back to idle; a one restarts at GLAB_KEY_ONE
					if (!wdata[KEY_BIT] && wdata[15:0] == pins_reg) begin
						state_next = GLAB_KEY_ZERO;
					end else if (wdata[KEY_BIT]) begin
						state_next = GLAB_KEY_ONE;
						pins_next = wdata[15:0];
					end else begin
						state_next = GLAB_KEY_IDLE;
					end
				end
				GLAB_KEY_ZERO: begin
					if (wdata[KEY_BIT] && wdata[15:0] == pins_reg) begin
						state_next = GLAB_KEY_DONE;
					end else begin
						state_next = GLAB_KEY_IDLE;
					end
				end
				default: begin
					state_next = GLAB_KEY_IDLE;
				end
			endcase
		end
	end

	// Tracker starts idle after reset
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= GLAB_KEY_IDLE;
			pins_reg <= RESET_VALUE[15:0];
		end else begin
			state_reg <= state_next;
			pins_reg <= pins_next;
		end
	end

	assign key_active = (state_reg == GLAB_KEY_DONE);

	// Once done, stays done until reset
	key_sticky_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		key_active |=> key_active) else $error("key dropped after activation");
endmodule : glab_key_seq
`default_nettype wire

// ===== design/glab_regs.sv
`timescale 1ns/1ps
`default_nettype none
module glab_regs (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic wr,
	input wire logic [31:0] wdata,
	input wire logic [31:0] locked,
	output logic [31:0] q
);
	import glab_pkg::*;

	logic [31:0] q_reg;
	logic [31:0] q_next;

	// ****************************************
	// Selector word, four bits per pin
	// ****************************************
	// Fields of locked pins keep their value
	always_comb begin
		q_next = q_reg;
		if (wr) begin
			q_next = (q_reg & locked) | (wdata & ~locked);
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			q_reg <= RESET_VALUE;
		end else begin
			q_reg <= q_next;
		end
	end

	assign q = q_reg;
endmodule : glab_regs
`default_nettype wire

// ===== testbench/glab_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module glab_top_bench;
	import glab_pkg::*;
	// ****************************************
	// Clock, reset and port signals
	// ****************************************
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [15:0] pin_freeze_bit;
	logic [31:0] alt_function_select_low;
	logic [31:0] alt_function_select_high;
	logic [15:0] pin_output_clear_bit;
	logic pin_output_clear_stb;
	logic clr_stb_seen;
	logic [15:0] clr_mask_seen;
	int n_errors = 0;
	int total_checks = 0;

	// Free-running 100 MHz clock
	always #5 core_clk = ~core_clk;

	glab_top uut (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.pin_freeze_bit(pin_freeze_bit),
		.alt_function_select_low(alt_function_select_low),
		.alt_function_select_high(alt_function_select_high),
		.pin_output_clear_bit(pin_output_clear_bit),
		.pin_output_clear_stb(pin_output_clear_stb)
	);

	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Values seen here are pre-edge, so no race with the design's updates
	task automatic bus_wait;
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (avs_waitrequest !== 1'b0) begin
			n_errors++;
			$display("ERROR at %0t: no bus answer", $time);
		end
	endtask : bus_wait

	// One idle edge after release, so a strobe is never set twice at once
	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= 1'b1;
		bus_wait();
		clr_stb_seen = pin_output_clear_stb;
		clr_mask_seen = pin_output_clear_bit;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic [31:0] exp);
		avs_address <= a;
		avs_read <= 1'b1;
		bus_wait();
		check(avs_readdata, exp);
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask : rd

	task automatic key_seq(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
		wr(OFS_LOCK, a, 4'hf);
		wr(OFS_LOCK, b, 4'hf);
		wr(OFS_LOCK, c, 4'hf);
	endtask : key_seq

	task automatic end_of_test;
		$display("errors %0d checks %0d", n_errors, total_checks);
		if (n_errors == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test

	// Whole run is about 140 cycles; this leaves ample margin
	initial begin
		#100000;
		n_errors++;
		$display("ERROR at %0t: timeout", $time);
		end_of_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		rd(OFS_LOCK, RESET_VALUE);
		rd(OFS_ALFL, ZERO_WORD);
		rd(OFS_ALFH, ZERO_WORD);
		rd(OFS_BCLR, ZERO_WORD);
		rd(6'h00, ZERO_WORD);
		wr(OFS_ALFL, 32'h7654_3210, 4'hf);
		rd(OFS_ALFL, 32'h7654_3210);
		check(alt_function_select_low, 32'h7654_3210);
		wr(OFS_ALFH, 32'h0123_4567, 4'hf);
		wr(OFS_ALFH, 32'h3333_3333, 4'h1);
		rd(OFS_ALFH, 32'h0123_4533);
		wr(OFS_BCLR, 32'hffff_a5a5, 4'hf);
		check({15'h0, clr_stb_seen, clr_mask_seen}, {15'h0, 1'b1, 16'ha5a5});
		check({31'h0, pin_output_clear_stb}, ZERO_WORD);
		rd(OFS_BCLR, ZERO_WORD);
		wr(OFS_LOCK, 32'h0000_00ff, 4'hf);
		rd(OFS_LOCK, 32'h0000_00ff);
		// Wrong order, then changed pin bits: key must stay off
		key_seq(32'h0001_0f0f, 32'h0000_0f0f, 32'h0000_0f0f);
		rd(OFS_LOCK, 32'h0000_0f0f);
		key_seq(32'h0001_0f0f, 32'h0000_0ff0, 32'h0001_0ff0);
		rd(OFS_LOCK, 32'h0000_0ff0);
		key_seq(32'h0001_00f3, 32'h0000_00f3, 32'h0001_00f3);
		rd(OFS_LOCK, 32'h0001_00f3);
		rd(OFS_LOCK, 32'h0001_00f3);
		check({16'h0, pin_freeze_bit}, 32'h0000_00f3);
		wr(OFS_LOCK, 32'h0000_0000, 4'hf);
		rd(OFS_LOCK, 32'h0001_00f3);
		key_seq(32'h0001_ff00, 32'h0000_ff00, 32'h0001_ff00);
		rd(OFS_LOCK, 32'h0001_00f3);
		// In the low register only the nibbles of pins 2 and 3 are unlocked; pins 8 to 15 are all unlocked
		wr(OFS_ALFL, 32'h1111_1111, 4'hf);
		rd(OFS_ALFL, 32'h7654_1110);
		wr(OFS_ALFH, 32'h2222_2222, 4'hf);
		rd(OFS_ALFH, 32'h2222_2222);
		check(alt_function_select_high, 32'h2222_2222);
		// Reset in mid-run clears the lock and restarts the tracker
		arst_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		rd(OFS_LOCK, RESET_VALUE);
		rd(OFS_ALFL, ZERO_WORD);
		rd(OFS_ALFH, ZERO_WORD);
		check({16'h0, pin_freeze_bit}, RESET_VALUE);
		key_seq(32'h0001_8000, 32'h0000_8000, 32'h0001_8000);
		rd(OFS_LOCK, 32'h0001_8000);
		end_of_test();
	end
endmodule : glab_top_bench
`default_nettype wire
